// [encoder_event_time_counter.sv]
// Purpose: incremental counter channel: events, distance, angle and time per interval.
// Assumes: comparator outputs arrive asynchronously; APB master per protocol.
// Notes: one result per sampling interval, pulsed on resultValid.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module encoder_event_time_counter #(
   parameter logic [31:0] DEFAULT_INTERVAL = enc_pkg::INTERVAL_RESET
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trackA,
   input wire logic trackB,
   input wire logic indexPulse,
   output logic [15:0] result,
   output logic resultValid
);
   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [11:0] ctrl;
   logic [15:0] gain;
   logic [31:0] interval;
   logic runPrev, started, overflow, timeValid, mapped, wrEn, startPulse, run, dual, indexEn;
   logic [3:0] range;
   enc_pkg::mode_t mode;
   enc_pkg::edge_t edgeSel;

   assign run = ctrl[enc_pkg::CTRL_RUN_BIT];
   assign mode = enc_pkg::mode_t'(ctrl[enc_pkg::CTRL_MODE_LSB +: 3]);
   assign dual = ctrl[enc_pkg::CTRL_DUAL_BIT];
   assign indexEn = ctrl[enc_pkg::CTRL_INDEX_BIT];
   assign edgeSel = enc_pkg::edge_t'(ctrl[enc_pkg::CTRL_EDGE_LSB +: 2]);
   assign range = ctrl[enc_pkg::CTRL_RANGE_LSB +: 4];

   ////////////////////////////////////////////////////////////////////////////
   // apb slave with zero wait states
   always_comb begin
      if (paddr == enc_pkg::CTRL_OFFSET) begin
         mapped = 1'b1;
      end else if (paddr == enc_pkg::GAIN_OFFSET) begin
         mapped = 1'b1;
      end else if (paddr == enc_pkg::INTERVAL_OFFSET) begin
         mapped = 1'b1;
      end else if (paddr == enc_pkg::RESULT_OFFSET) begin
         mapped = 1'b1;
      end else if (paddr == enc_pkg::STATUS_OFFSET) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wrEn = psel & penable & pwrite & mapped;

   // read mux sampled in setup so prdata is a flop during the access phase
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == enc_pkg::CTRL_OFFSET) begin
            prdata <= {20'h00000, ctrl};
         end else if (paddr == enc_pkg::GAIN_OFFSET) begin
            prdata <= {16'h0000, gain};
         end else if (paddr == enc_pkg::INTERVAL_OFFSET) begin
            prdata <= interval;
         end else if (paddr == enc_pkg::RESULT_OFFSET) begin
            prdata <= {16'h0000, result};
         end else if (paddr == enc_pkg::STATUS_OFFSET) begin
            prdata <= {28'h0000000, run, timeValid, overflow, started};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // writable configuration: mode, track count, index use, edges, range, gain
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl <= enc_pkg::CTRL_RESET;
         gain <= enc_pkg::GAIN_RESET;
         interval <= DEFAULT_INTERVAL;
      end else if (wrEn) begin
         if (paddr == enc_pkg::CTRL_OFFSET) begin
            ctrl <= pwdata[11:0]; // RULE_03
         end else if (paddr == enc_pkg::GAIN_OFFSET) begin
            gain <= pwdata[15:0]; // RULE_17
         end else if (paddr == enc_pkg::INTERVAL_OFFSET) begin
            interval <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic aLevel, aRise, aFall, bLevel, idxRise;

   pin_sync syncA (
      .mclk(mclk), .rst(rst), .pin(trackA),
      .level(aLevel), .rise(aRise), .fall(aFall)
   );
   pin_sync syncB (
      .mclk(mclk), .rst(rst), .pin(trackB),
      .level(bLevel), .rise(), .fall()
   );
   pin_sync syncIdx (
      .mclk(mclk), .rst(rst), .pin(indexPulse),
      .level(), .rise(idxRise), .fall()
   );

   ////////////////////////////////////////////////////////////////////////////
   // measurement start and index arming
   assign startPulse = run & ~runPrev;

   // with index use nothing counts until the first index edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         runPrev <= 1'b0;
         started <= 1'b0;
      end else begin
         runPrev <= run;
         if (!run) begin
            started <= 1'b0;
         end else if (startPulse) begin
            started <= ~indexEn; // RULE_18
         end else if (idxRise) begin
            started <= 1'b1; // RULE_18
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // step decoding
   logic [1:0] prevAB;
   logic stepUp, stepDn;

   always_ff @(posedge mclk) begin
      if (rst) begin
         prevAB <= 2'h0;
      end else begin
         prevAB <= {aLevel, bLevel};
      end
   end

   // quadrature gives four steps per pulse, which caps usable resolution
   always_comb begin
      stepUp = 1'b0;
      stepDn = 1'b0;
      if (!dual) begin
         stepUp = aRise; // RULE_02
      end else begin
         case ({prevAB, aLevel, bLevel}) // RULE_19 RULE_10
            4'b0001, 4'b0111, 4'b1110, 4'b1000: stepUp = 1'b1;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: stepDn = 1'b1;
            default: stepUp = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sampling interval timer
   logic [31:0] timer;
   logic sampleTick;

   assign sampleTick = run && (timer == interval - 32'h0000_0001);

   always_ff @(posedge mclk) begin
      if (rst) begin
         timer <= 32'h0000_0000;
      end else if (!run || startPulse || sampleTick) begin
         timer <= 32'h0000_0000;
      end else begin
         timer <= timer + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event and step counters
   logic [15:0] eventCount;
   logic signed [15:0] diffCount, position;
   logic indexSeen, counting, posWrap, idxZero;

   assign counting = run & started;
   assign posWrap = (stepUp && position == enc_pkg::POS_MAX) ||
                    (stepDn && position == enc_pkg::POS_MIN);
   // absolute angle zeroes on every index; distance and summed angle only once
   assign idxZero = run && idxRise &&
                    (mode == enc_pkg::MODE_ANGLE_ABS || !indexSeen);

   // per-interval counts; an edge on the tick cycle opens the next interval
   always_ff @(posedge mclk) begin
      if (rst) begin
         eventCount <= 16'h0000;
         diffCount <= 16'sh0000;
      end else if (!counting || sampleTick) begin
         eventCount <= (counting && aRise) ? 16'h0001 : 16'h0000; // RULE_01
         diffCount <= !counting ? 16'sh0000 : stepUp ? 16'sh0001 :
                      stepDn ? -16'sh0001 : 16'sh0000; // RULE_04 RULE_06
      end else begin
         if (aRise && eventCount != 16'hFFFF) begin
            eventCount <= eventCount + 16'h0001; // RULE_01
         end
         if (stepUp) begin
            diffCount <= diffCount + 16'sh0001;
         end else if (stepDn) begin
            diffCount <= diffCount - 16'sh0001;
         end
      end
   end

   // signed 16-bit position wraps on overflow, flagged in status
   always_ff @(posedge mclk) begin
      if (rst) begin
         position <= 16'sh0000;
         indexSeen <= 1'b0;
      end else if (startPulse || !run) begin
         position <= 16'sh0000; // RULE_05 RULE_07
         indexSeen <= 1'b0;
      end else if (idxZero) begin
         position <= 16'sh0000; // RULE_07 RULE_08
         indexSeen <= 1'b1;
      end else if (counting && posWrap) begin
         position <= stepUp ? enc_pkg::POS_MIN : enc_pkg::POS_MAX; // RULE_09
      end else if (counting && stepUp) begin
         position <= position + 16'sh0001; // RULE_05
      end else if (counting && stepDn) begin
         position <= position - 16'sh0001; // RULE_05
      end
   end

   // overflow is sticky until the next start; a wrap in an index-zero cycle does not set it
   always_ff @(posedge mclk) begin
      if (rst) begin
         overflow <= 1'b0;
      end else if (counting && posWrap && !idxZero) begin
         overflow <= 1'b1; // RULE_09
      end else if (startPulse) begin
         overflow <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // time measurement on track A
   logic timing, startEdge, stopEdge, timeOn;
   logic [17:0] presc, lsbLimit;
   logic [15:0] ticks, lastTime;

   // lsb doubles with every range step
   assign lsbLimit = (enc_pkg::TIME_LSB_CYCLES << range) - 18'h00001; // RULE_14
   assign timeOn = counting && mode == enc_pkg::MODE_TIME && edgeSel != enc_pkg::EDGE_FALL_FALL;

   // fall to fall is refused and simply never measures
   always_comb begin
      case (edgeSel) // RULE_11 RULE_12
         enc_pkg::EDGE_RISE_FALL: begin
            startEdge = aRise;
            stopEdge = aFall;
         end
         enc_pkg::EDGE_FALL_RISE: begin
            startEdge = aFall;
            stopEdge = aRise;
         end
         enc_pkg::EDGE_RISE_RISE: begin
            startEdge = aRise;
            stopEdge = aRise;
         end
         default: begin
            startEdge = 1'b0;
            stopEdge = 1'b0;
         end
      endcase
   end

   // a later completion overwrites an earlier one in the same interval
   always_ff @(posedge mclk) begin
      if (rst) begin
         timing <= 1'b0;
         presc <= 18'h00000;
         ticks <= 16'h0000;
         lastTime <= 16'h0000;
         timeValid <= 1'b0;
      end else if (startPulse || !timeOn) begin
         timing <= 1'b0;
         presc <= 18'h00000;
         ticks <= 16'h0000;
         if (startPulse) begin
            lastTime <= 16'h0000; // RULE_15
            timeValid <= 1'b0;
         end
      end else if (timing && stopEdge) begin
         lastTime <= ticks; // RULE_16
         timeValid <= 1'b1;
         timing <= (edgeSel == enc_pkg::EDGE_RISE_RISE);
         presc <= 18'h00001;
         ticks <= 16'h0000;
      end else if (!timing && startEdge) begin
         timing <= 1'b1;
         presc <= 18'h00001; // the edge cycle counts too
         ticks <= 16'h0000;
      end else if (timing) begin
         if (presc >= lsbLimit) begin
            presc <= 18'h00000;
            if (ticks != enc_pkg::TIME_FULL) begin
               ticks <= ticks + 16'h0001; // RULE_13
            end
         end else begin
            presc <= presc + 18'h00001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scaling and result
   // gain is unsigned fixed point; software derives it from pulses per unit
   function automatic logic [15:0] scaleCount(input logic signed [15:0] cnt,
                                               input logic [15:0] g);
      logic signed [32:0] prod;
      logic signed [24:0] shifted;
      prod = 33'(cnt) * $signed({17'h00000, g});
      shifted = prod[enc_pkg::GAIN_FRAC +: 25];
      if (shifted > 25'sd32767) begin
         scaleCount = 16'h7FFF;
      end else if (shifted < -25'sd32767) begin
         scaleCount = 16'h8001;
      end else begin
         scaleCount = shifted[15:0];
      end
   endfunction : scaleCount

   logic [15:0] next_result;

   always_comb begin
      case (mode)
         enc_pkg::MODE_EVENTS: next_result = eventCount; // RULE_01
         enc_pkg::MODE_DIST_DIFF: next_result = scaleCount(diffCount, gain); // RULE_04
         enc_pkg::MODE_ANGLE_DIFF: next_result = scaleCount(diffCount, gain); // RULE_06
         enc_pkg::MODE_DIST_ABS: next_result = scaleCount(position, gain); // RULE_05
         enc_pkg::MODE_ANGLE_ABS: next_result = scaleCount(position, gain); // RULE_07
         enc_pkg::MODE_ANGLE_SUM: next_result = scaleCount(position, gain); // RULE_08
         enc_pkg::MODE_TIME: next_result = lastTime; // RULE_15
         default: next_result = 16'h0000;
      endcase
   end

   // one result per interval; zero while index use still waits for its pulse
   always_ff @(posedge mclk) begin
      if (rst) begin
         result <= 16'h0000;
         resultValid <= 1'b0;
      end else begin
         resultValid <= sampleTick;
         if (sampleTick) begin
            result <= started ? next_result : 16'h0000; // RULE_17
         end
      end
   end
endmodule : encoder_event_time_counter

// [enc_pkg.sv]
// Purpose: shared constants and types for the encoder event and time counter.
// Assumes: 125 MHz mclk, APB register access with 32-bit data.
// Notes: offsets, fields, reset values and timing counts.
// How it works
// [RULE_01] event mode counts pulses per sampling interval, up to about 500 kHz
// [RULE_02] one event is a rising edge of the conditioned input
// [RULE_03] settings: single or dual track, index start or not, pulses-per-unit gain
// [RULE_04] differential distance: interval step count times the distance gain
// [RULE_05] absolute distance: accumulated position, zero at start or at index
// [RULE_06] differential angle: interval step count times the angle gain
// [RULE_07] absolute angle: accumulated angle referenced to every index pulse
// [RULE_08] summed angle: accumulated, index honoured once, may pass one turn
// [RULE_09] position counter is signed 16 bits, range plus or minus 32767
// [RULE_10] dual track counts four steps per pulse, so 8192 pulses per turn
// [RULE_11] time mode measures rise to fall, fall to rise or rise to rise
// [RULE_12] software must not pick fall to fall edge pairing
// [RULE_13] interval longer than the range reads as the full-scale value
// [RULE_14] time LSB is 31.25 ns at 1 ms range, doubling with each range step; the code rounds it to 4 clocks, 32 ns
// [RULE_15] no completed time repeats the last result, zero before any result
// [RULE_16] several completed times in one interval report only the last
// [RULE_17] gain maps the configured maximum onto the 16-bit output format
// [RULE_18] with index use counting starts at the first index pulse
// [RULE_19] dual track decodes two quadrature tracks into signed direction
// [RULE_20] pin inputs pass two flip-flops before edge detection
package enc_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] GAIN_OFFSET = 8'h04;
   localparam logic [7:0] INTERVAL_OFFSET = 8'h08;
   localparam logic [7:0] RESULT_OFFSET = 8'h0C;
   localparam logic [7:0] STATUS_OFFSET = 8'h10;
   // control field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_DUAL_BIT = 4;
   localparam int CTRL_INDEX_BIT = 5;
   localparam int CTRL_EDGE_LSB = 6;
   localparam int CTRL_RANGE_LSB = 8;
   // status field positions
   localparam int STAT_STARTED_BIT = 0;
   localparam int STAT_OVERFLOW_BIT = 1;
   localparam int STAT_TIMEVALID_BIT = 2;
   localparam int STAT_RUN_BIT = 3;
   // reset values
   localparam logic [11:0] CTRL_RESET = 12'h000;
   localparam logic [15:0] GAIN_RESET = 16'h0100;
   localparam int GAIN_FRAC = 8;
   // timing: clock, sampling interval and time LSB
   localparam int CLK_PERIOD_PS = 8000;
   localparam int SAMPLE_US = 1000;
   localparam logic [31:0] INTERVAL_RESET = 32'((SAMPLE_US * 1000000) / CLK_PERIOD_PS);
   localparam int TIME_LSB_PS = 31250;
   localparam logic [17:0] TIME_LSB_CYCLES =
      18'((TIME_LSB_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);
   localparam logic [15:0] TIME_FULL = 16'h7FFF;
   localparam logic signed [15:0] POS_MAX = 16'sh7FFF;
   localparam logic signed [15:0] POS_MIN = -16'sh7FFF;

   typedef enum logic [2:0] {
      MODE_EVENTS, MODE_DIST_DIFF, MODE_DIST_ABS, MODE_ANGLE_DIFF,
      MODE_ANGLE_ABS, MODE_ANGLE_SUM, MODE_TIME, MODE_SPARE
   } mode_t;

   typedef enum logic [1:0] {
      EDGE_RISE_FALL, EDGE_FALL_RISE, EDGE_RISE_RISE, EDGE_FALL_FALL
   } edge_t;
endpackage : enc_pkg

// [pin_sync.sv]
// Purpose: two-stage synchroniser with edge detection for one pin.
// Assumes: the pin is asynchronous to mclk.
// Notes: edges appear two clocks after the pin moves.
`timescale 1ns/1ps
module pin_sync (
   input wire logic mclk,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic stage1;
   logic stage2;

   // first stage is seen only by the second, keeping metastability out of logic
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         level <= 1'b0;
      end else begin
         stage1 <= pin; // RULE_20
         stage2 <= stage1; // RULE_20
         level <= stage2;
      end
   end

   // each transition gives exactly one pulse
   assign rise = stage2 & ~level;
   assign fall = ~stage2 & level;
endmodule : pin_sync

// [enc_counter_properties.sv]
// Purpose: port-level properties of the encoder event and time counter.
// Assumes: run, mode and interval are tracked from completed APB writes.
// Notes: pready is zero-wait, so psel with penable marks a finishing access.
`timescale 1ns/1ps
module enc_counter_properties #(
   parameter logic [31:0] DEFAULT_INTERVAL = enc_pkg::INTERVAL_RESET
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] result,
   input wire logic resultValid
);
   ////////////////////////////////////////////////////////////////////////
   logic acc, mapped, start, runOn, seen;
   logic [2:0] mode;
   logic [31:0] ivl, gap;
   // access decode; a run write while stopped is a measurement start
   assign acc = psel && penable;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
   assign start = acc && pwrite && paddr == 8'h00 && pwdata[0] && !runOn;
   // shadow of the settings as software wrote them
   always_ff @(posedge mclk) begin
      if (rst) begin
         runOn <= 1'b0;
         mode <= 3'h0;
         ivl <= DEFAULT_INTERVAL;
      end else if (acc && pwrite && paddr == 8'h00) begin
         runOn <= pwdata[0];
         mode <= pwdata[3:1];
      end else if (acc && pwrite && paddr == 8'h08) begin
         ivl <= (pwdata == 32'h0) ? 32'h1 : pwdata; // zero is stored as one
      end
   end
   // cycles since the run began or since the last result
   always_ff @(posedge mclk) begin
      if (rst || start) begin
         gap <= 32'h0;
         seen <= 1'b0;
      end else if (resultValid) begin
         gap <= 32'h1;
         seen <= 1'b1;
      end else begin
         gap <= gap + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_pready_zero_wait: assert property (acc |-> pready)
      else $error("access phase without pready");
   a_mapped_no_error: assert property (acc && mapped |-> !pslverr)
      else $error("error flagged on a mapped register");
   a_unmapped_refused: assert property (acc && !mapped |->
      pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_error_in_access: assert property (!acc |-> !pslverr)
      else $error("error outside an access phase");
   a_tick_period: assert property (resultValid && runOn |->
      (seen ? gap == ivl : gap == ivl + 32'h1))
      else $error("result off the interval");
   a_result_held: assert property ($changed(result) |-> resultValid)
      else $error("result moved without a tick");
   a_valid_single: assert property (resultValid && ivl > 32'h1 |=> !resultValid)
      else $error("strobe too long");
   a_stopped_quiet: assert property (!runOn [*3] |-> !resultValid)
      else $error("result produced while stopped");
   a_time_full: assert property (resultValid && mode == 3'h6 |->
      result <= enc_pkg::TIME_FULL)
      else $error("time result beyond full scale");
   a_pos_range: assert property (resultValid && mode inside {[3'h1:3'h5]} |->
      result != 16'h8000)
      else $error("position out of range");
endmodule : enc_counter_properties

// [enc_sensor.sv]
// Purpose: behavioural incremental encoder with index, as seen after the comparator.
// Assumes: pins move on mclk edges, so no level is shorter than one clock.
// Notes: pins rest at their last level between moves, as a real comparator does.
`timescale 1ns/1ps
module enc_sensor (
   input wire logic mclk,
   output logic trackA,
   output logic trackB,
   output logic indexPulse
);
   ////////////////////////////////////////////////////////////////////////
   // pins idle low until the bench moves them
   initial begin
      trackA = 1'b0;
      trackB = 1'b0;
      indexPulse = 1'b0;
   end
   // n full pulses, tracks a quarter period apart; up runs 00,01,11,10 on {A,B}
   task automatic pulses(input int n, input bit up, input int q);
      logic [7:0] seq;
      seq = up ? 8'b01_11_10_00 : 8'b10_11_01_00;
      for (int i = 0; i < 4 * n; i++) begin
         {trackA, trackB} <= seq[7 - 2 * (i % 4) -: 2];
         repeat (q) @(posedge mclk);
      end
   endtask : pulses
   // single-track level for time measurement
   task automatic level(input logic v, input int c);
      trackA <= v;
      repeat (c) @(posedge mclk);
   endtask : level
   // short zero pulse
   task automatic index;
      indexPulse <= 1'b1;
      repeat (2) @(posedge mclk);
      indexPulse <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : index
endmodule : enc_sensor

// [tb_top.sv]
// Purpose: self-checking bench for the encoder event and time counter.
// Assumes: the sensor model moves the pins on clock edges; APB is zero-wait.
// Notes: short intervals keep the run brief; position overflow is not exercised.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   checksDone++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
   end \
end
module tb_top;
   localparam logic [31:0] IVL0 = 32'h14;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, resultValid, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] result;
   logic trackA, trackB, indexPulse;
   int failures, checksDone;
   ////////////////////////////////////////////////////////////////////////
   enc_sensor sens (.mclk, .trackA, .trackB, .indexPulse);
   encoder_event_time_counter #(.DEFAULT_INTERVAL(IVL0)) uut (.mclk, .rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .trackA,
      .trackB, .indexPulse, .result, .resultValid);
   // 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////
   // one APB transfer; holds the request until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // wait for the next result strobe
   task automatic tick;
      do @(posedge mclk); while (resultValid !== 1'b1);
   endtask : tick
   // restart in a mode and wait out the first interval
   task automatic start(input logic [2:0] md, input logic dl, input logic ix,
      input logic [1:0] eg, input logic [3:0] rg, input logic [31:0] iv);
      apb(1'b1, enc_pkg::CTRL_OFFSET, 32'h0);
      apb(1'b1, enc_pkg::INTERVAL_OFFSET, iv);
      apb(1'b1, enc_pkg::CTRL_OFFSET, {20'h0, rg, eg, ix, dl, md, 1'b1});
      tick;
   endtask : start
   // reset values, read-only and unmapped places
   task automatic t_regs;
      apb(1'b0, enc_pkg::GAIN_OFFSET, 32'h0);
      `CHK("gain", 32'h0100, rdata)
      apb(1'b0, enc_pkg::INTERVAL_OFFSET, 32'h0);
      `CHK("interval", IVL0, rdata)
      apb(1'b1, enc_pkg::RESULT_OFFSET, 32'h1234);
      apb(1'b0, enc_pkg::RESULT_OFFSET, 32'h0);
      `CHK("result reg", 32'h0, rdata)
      apb(1'b1, 8'h14, 32'h5);
      `CHK("unmapped error", 1'b1, rerr)
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped data", 32'h0, rdata)
      apb(1'b1, enc_pkg::INTERVAL_OFFSET, 32'h0);
      apb(1'b0, enc_pkg::INTERVAL_OFFSET, 32'h0);
      `CHK("interval zero", 32'h1, rdata)
      $display("t_regs done");
   endtask : t_regs
   // events per interval, then an empty interval
   task automatic t_events;
      start(enc_pkg::MODE_EVENTS, 1'b0, 1'b0, 2'h0, 4'h0, 32'd60);
      sens.pulses(5, 1'b1, 2);
      tick;
      `CHK("events", 16'd5, result)
      tick;
      `CHK("events none", 16'd0, result)
      $display("t_events done");
   endtask : t_events
   // differential distance in both directions, single-track angle upwards, two gains
   task automatic t_quad;
      apb(1'b1, enc_pkg::GAIN_OFFSET, 32'h0180);
      start(enc_pkg::MODE_DIST_DIFF, 1'b1, 1'b0, 2'h0, 4'h0, 32'd60);
      sens.pulses(3, 1'b1, 2);
      tick;
      `CHK("dist up", 16'd18, result)
      sens.pulses(2, 1'b0, 2);
      tick;
      `CHK("dist down", 16'hFFF4, result)
      apb(1'b1, enc_pkg::GAIN_OFFSET, 32'h0200);
      start(enc_pkg::MODE_ANGLE_DIFF, 1'b0, 1'b0, 2'h0, 4'h0, 32'd60);
      sens.pulses(3, 1'b1, 2);
      tick;
      `CHK("angle single", 16'd6, result)
      $display("t_quad done");
   endtask : t_quad
   // accumulated modes with and without the zero pulse
   task automatic t_abs;
      apb(1'b1, enc_pkg::GAIN_OFFSET, 32'h0100);
      start(enc_pkg::MODE_DIST_ABS, 1'b1, 1'b0, 2'h0, 4'h0, 32'd60);
      sens.pulses(2, 1'b1, 2);
      tick;
      `CHK("dist abs", 16'd8, result)
      sens.pulses(1, 1'b1, 2);
      tick;
      `CHK("dist abs sum", 16'd12, result)
      start(enc_pkg::MODE_ANGLE_ABS, 1'b1, 1'b1, 2'h0, 4'h0, 32'd60);
      sens.pulses(2, 1'b1, 2);
      tick;
      `CHK("before index", 16'd0, result)
      for (int i = 0; i < 2; i++) begin
         sens.index;
         sens.pulses(1, 1'b1, 2);
         tick;
         `CHK("angle abs", 16'd4, result)
      end
      start(enc_pkg::MODE_ANGLE_SUM, 1'b1, 1'b1, 2'h0, 4'h0, 32'd60);
      for (int i = 1; i < 3; i++) begin
         sens.index;
         sens.pulses(1, 1'b1, 2);
         tick;
         `CHK("angle sum", 16'(4 * i), result)
      end
      $display("t_abs done");
   endtask : t_abs
   // rise-fall, fall-rise and rise-rise pairings, two ranges, two measurements in one interval
   task automatic t_time;
      logic [1:0] eg [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
      logic [15:0] ex [4] = '{16'hC, 16'h6, 16'h10, 16'h6};
      for (int i = 0; i < 4; i++) begin
         start(enc_pkg::MODE_TIME, 1'b0, 1'b0, eg[i], (i == 3) ? 4'h1 : 4'h0, 32'd200);
         `CHK("time first", 16'd0, result)
         sens.level(1'b1, 40);
         sens.level(1'b0, 24);
         sens.level(1'b1, 48);
         sens.level(1'b0, 4);
         tick;
         `CHK("time", ex[i], result)
         tick;
         `CHK("time repeat", ex[i], result)
      end
      $display("t_time done");
   endtask : t_time
   // counts, verdict and end of run
   task automatic conclude;
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////
   // reset for three clocks, then the scenarios in turn
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_regs;
      t_events;
      t_quad;
      t_abs;
      t_time;
      conclude;
   end
   // watchdog well past the expected few thousand cycles
   initial begin
      #(8 * 30000);
      failures++;
      conclude;
   end
endmodule : tb_top
bind encoder_event_time_counter enc_counter_properties #(.DEFAULT_INTERVAL(DEFAULT_INTERVAL))
   chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .result, .resultValid);
